// File: hdl/ufeam_addr_match.sv
// Purpose: given and broadcast address comparison
// Assumes: purely combinational, read in the frame-done cycle
// Notes:   zero mask means every byte matches

module ufeam_addr_match (
  input  wire logic [7:0] rx_byte_i,
  input  wire logic [7:0] slave_address_i,
  input  wire logic [7:0] slave_address_mask_i,
  output logic            given_o,
  output logic            broadcast_o,
  output logic            match_o
);
  import ufeam_pkg::*;

  // ****************************************************************
  // comparison
  // ****************************************************************
  // R9: masked given compare
  assign given_o     = ((rx_byte_i ^ slave_address_i) & slave_address_mask_i) == 8'h_0000;
  // R10: ones of the or are the only cared bits
  assign broadcast_o = ((~rx_byte_i) & (slave_address_i | slave_address_mask_i)) == 8'h_0000;
  assign match_o     = given_o | broadcast_o;

endmodule

// File: hdl/ufeam_pkg.sv
// Purpose: shared constants and types of the serial receive extension
// Assumes: one clock, synchronous active-high reset
// Notes:   register byte address is four times the register index

// ****************************************************************
// package
// ****************************************************************
package ufeam_pkg;

  // bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // register indices, byte address = index * 4
  localparam logic [7:0] IDX_SLAVE_ADDRESS      = 8'h_00A9;
  localparam logic [7:0] IDX_SLAVE_ADDRESS_MASK = 8'h_00B9;
  localparam logic [7:0] IDX_SERIAL_CONTROL     = 8'h_00C0;
  localparam logic [7:0] IDX_POWER_CONTROL      = 8'h_00C1;
  localparam logic [7:0] IDX_SERIAL_BUFFER      = 8'h_00C2;
  localparam logic [7:0] IDX_BAUD_DIV           = 8'h_00C3;
  localparam logic [7:0] IDX_IRQ_STATUS         = 8'h_00C4;
  localparam logic [7:0] IDX_IRQ_MASK           = 8'h_00C5;

  // serial control bit positions
  localparam int SC_SHARED_BIT   = 7;
  localparam int SC_MODE_LOW_BIT = 6;
  localparam int SC_FILTER_BIT   = 5;
  localparam int SC_RX_EN_BIT    = 4;
  localparam int SC_NINTH_BIT    = 2;
  localparam int SC_RX_DONE_BIT  = 0;
  // power control bit position
  localparam int PC_VIEW_BIT     = 6;
  // interrupt status and mask bit positions
  localparam int IRQ_RX_DONE_BIT = 0;
  localparam int IRQ_FE_BIT      = 1;
  localparam int IRQ_W           = 2;

  // reset values
  localparam logic [7:0]  SLAVE_ADDRESS_RST      = 8'h_0000;
  localparam logic [7:0]  SLAVE_ADDRESS_MASK_RST = 8'h_0000;
  localparam logic [15:0] BAUD_DIV_RST           = 16'h_001A;

  // oversampling slices in which the line is voted, and index of the last data bit
  localparam logic [3:0] VOTE_FIRST  = 4'h_7;
  localparam logic [3:0] VOTE_SECOND = 4'h_8;
  localparam logic [3:0] VOTE_LAST   = 4'h_9;
  localparam logic [3:0] LAST_BIT_8  = 4'h_7;
  localparam logic [3:0] LAST_BIT_9  = 4'h_8;

  // receiver states, one-hot
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } ufeam_rx_state_type;

  // one received frame
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       ninth;
    logic       stop;
  } ufeam_frame_type;

  // avalon-mm request and response
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [3:0]        byteenable;
    logic [DATA_W-1:0] writedata;
  } ufeam_avs_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
  } ufeam_avs_rsp_type;

endpackage

// File: hdl/ufeam_rx_sampler.sv
// Purpose: start detect, 2-of-3 voting and framing of received bits
// Assumes: tick_i pulses at sixteen times the bit rate
// Notes:   frame_o.valid is a one-cycle pulse at mid stop bit

module ufeam_rx_sampler (
  input  wire logic                      ref_clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      ce_i,
  input  wire logic                      tick_i,
  input  wire logic                      rxd_i,
  input  wire logic                      enable_i,
  input  wire logic                      nine_bit_i,
  output ufeam_pkg::ufeam_frame_type     frame_o
);
  import ufeam_pkg::*;

  typedef struct packed {
    ufeam_rx_state_type state;
    logic [3:0]         slice;
    logic [3:0]         bitn;
    logic [8:0]         shreg;
    logic [1:0]         votes;
    logic               rxd_prev;
    ufeam_frame_type    frame;
  } ufeam_rx_core_type;

  localparam ufeam_rx_core_type CORE_RST = '{state: RX_IDLE, slice: 4'h_0, bitn: 4'h_0, shreg: 9'h_0000,
                                             votes: 2'h_0, rxd_prev: 1'b1, frame: '0};

  ufeam_rx_core_type core;
  ufeam_rx_core_type next_core;
  logic              bit_val;

  // ****************************************************************
  // next state
  // ****************************************************************
  // majority of the three mid-bit samples rejects short spikes
  assign bit_val = (core.votes[1] & core.votes[0]) | (core.votes[1] & rxd_i) | (core.votes[0] & rxd_i);

  always_comb begin
    next_core = core;
    next_core.frame.valid = 1'b0;
    if (tick_i) begin
      next_core.rxd_prev = rxd_i;
      next_core.slice = 4'(core.slice + 4'h_1);
      if (core.state == RX_IDLE) begin
        // falling edge realigns the slice counter
        if (enable_i && core.rxd_prev && !rxd_i) begin
          next_core.state = RX_START;
          next_core.slice = 4'h_1;
          next_core.bitn = 4'h_0;
        end
      end else begin
        if (core.slice == VOTE_FIRST) next_core.votes[1] = rxd_i;
        if (core.slice == VOTE_SECOND) next_core.votes[0] = rxd_i;
        if (core.slice == VOTE_LAST) begin
          unique case (core.state)
            RX_START: begin
              // a high start bit aborts the frame
              next_core.state = bit_val ? RX_IDLE : RX_DATA;
            end
            RX_DATA: begin
              next_core.shreg = {bit_val, core.shreg[8:1]};
              next_core.bitn = 4'(core.bitn + 4'h_1);
              if (core.bitn == (nine_bit_i ? LAST_BIT_9 : LAST_BIT_8)) next_core.state = RX_STOP;
            end
            RX_STOP: begin
              next_core.state = RX_IDLE;
              next_core.frame.valid = 1'b1;
              next_core.frame.data = nine_bit_i ? core.shreg[7:0] : core.shreg[8:1];
              next_core.frame.ninth = nine_bit_i ? core.shreg[8] : bit_val;
              next_core.frame.stop = bit_val;
            end
            RX_IDLE: begin
              next_core.state = RX_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      core <= CORE_RST;
    end else if (ce_i) begin
      core <= next_core;
    end
  end

  assign frame_o = core.frame;

endmodule

// File: hdl/ufeam_serial_rx.sv
// Purpose: serial receive port with framing error and address recognition
// Assumes: avalon-mm slave, one wait state per access, rxd_i synchronous
// Notes:   mode pair {high,low}: 01 ten-bit, 10/11 eleven-bit, 00 receiver off
//
// Summary of operation
// R1: a frame whose stop bit samples low sets the frame error flag.
// R2: serial control bit 7 shows the frame error flag when view select is 1, else mode select high.
// R3: the frame error flag is set only by hardware, cleared only by software, kept by good frames.
// R4: software keeps view select at 1 while it reads or writes the frame error flag.
// R5: nine-bit modes with the filter on accept only ninth-bit-high frames matching an address.
// R6: the remote master sends address bytes with the ninth bit high and data bytes with it low.
// R7: with the filter off every complete frame sets receive done, with no address compare.
// R8: ten-bit mode with the filter on accepts only frames with a good stop bit and matching byte.
// R9: the given address compares only bit positions where the mask is 1.
// R10: the broadcast address is slave address or mask, its zero bits ignored.
// R11: reset clears slave address and mask so every byte matches.
// R12: buffer, ninth bit and receive done load only while receive done is 0 and filter or stop allow.
// R13: nine-bit modes store the received ninth data bit in the received ninth bit.
// R14: writing 0 to the frame error flag with view select 1 clears it and keeps mode select high.

module ufeam_serial_rx (
  input  wire logic                  ref_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  ce_i,
  input  ufeam_pkg::ufeam_avs_req_type avs_req_i,
  output ufeam_pkg::ufeam_avs_rsp_type avs_rsp_o,
  input  wire logic                  rxd_i,
  output logic                       irq_o
);
  import ufeam_pkg::*;

  typedef struct packed {
    logic [7:0]        slave_address;
    logic [7:0]        slave_address_mask;
    logic              mode_select_high;
    logic              mode_select_low;
    logic              address_filter_enable;
    logic              rx_enable;
    logic              received_ninth_bit;
    logic              receive_done_flag;
    logic              frame_error_flag;
    logic              error_view_select;
    logic [7:0]        serial_buffer;
    logic [15:0]       baud_div;
    logic [15:0]       baud_cnt;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic              ack;
    logic [DATA_W-1:0] readdata;
  } ufeam_main_type;

  localparam ufeam_main_type MAIN_RST = '{slave_address: SLAVE_ADDRESS_RST,
                                          slave_address_mask: SLAVE_ADDRESS_MASK_RST,
                                          baud_div: BAUD_DIV_RST, default: '0};

  ufeam_main_type  st;
  ufeam_main_type  next_st;
  ufeam_frame_type frame;
  logic            tick;
  logic            nine_bit;
  logic            ten_bit;
  logic            rx_active;
  logic            given;
  logic            broadcast;
  logic            match;
  logic            filter_ok;
  logic            accept;
  logic            fe_event;
  logic            access;
  logic            wr_now;
  logic [7:0]      wr_idx;
  logic            fe_clear_wr;

  // ****************************************************************
  // sub-blocks
  // ****************************************************************
  ufeam_rx_sampler u_sampler (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .tick_i     (tick),
    .rxd_i      (rxd_i),
    .enable_i   (rx_active),
    .nine_bit_i (nine_bit),
    .frame_o    (frame)
  );

  ufeam_addr_match u_match (
    .rx_byte_i            (frame.data),
    .slave_address_i      (st.slave_address),
    .slave_address_mask_i (st.slave_address_mask),
    .given_o              (given),
    .broadcast_o          (broadcast),
    .match_o              (match)
  );

  // ****************************************************************
  // receive qualification
  // ****************************************************************
  // mode decode and frame acceptance
  // at or past the divider, so a smaller divider written mid-count never waits for a wrap
  assign tick      = (st.baud_cnt >= st.baud_div);
  assign nine_bit  = st.mode_select_high;
  assign ten_bit   = !st.mode_select_high && st.mode_select_low;
  assign rx_active = st.rx_enable && (st.mode_select_high || st.mode_select_low);
  // R5: nine-bit filter on ninth bit and address
  // R8: ten-bit filter on stop bit and address
  // R7: filter off passes every frame
  assign filter_ok = !st.address_filter_enable ||
                     (nine_bit ? (frame.ninth && match) : (ten_bit && frame.stop && match));
  // R12: a full receiver drops the frame
  assign accept    = frame.valid && rx_active && !st.receive_done_flag && filter_ok;
  // R1: low stop bit is a framing error
  assign fe_event  = frame.valid && rx_active && !frame.stop;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // one wait state: address is decoded, answer stands on the ack cycle
  assign access      = avs_req_i.read || avs_req_i.write;
  assign wr_now      = avs_req_i.write && st.ack && avs_req_i.byteenable[0];
  assign wr_idx      = avs_req_i.address[ADDR_W-1:2];
  assign fe_clear_wr = wr_now && wr_idx == IDX_SERIAL_CONTROL && st.error_view_select &&
                       !avs_req_i.writedata[SC_SHARED_BIT];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.baud_cnt = tick ? 16'h_0000 : 16'(st.baud_cnt + 16'h_0001);
    next_st.ack = access && !st.ack;
    // read mux, unmapped addresses read zero
    if (avs_req_i.read && !st.ack) begin
      next_st.readdata = '0;
      unique case (wr_idx)
        IDX_SLAVE_ADDRESS:      next_st.readdata[7:0] = st.slave_address;
        IDX_SLAVE_ADDRESS_MASK: next_st.readdata[7:0] = st.slave_address_mask;
        IDX_SERIAL_CONTROL: begin
          // R2: shared bit follows view select
          next_st.readdata[SC_SHARED_BIT] = st.error_view_select ? st.frame_error_flag : st.mode_select_high;
          next_st.readdata[SC_MODE_LOW_BIT] = st.mode_select_low;
          next_st.readdata[SC_FILTER_BIT] = st.address_filter_enable;
          next_st.readdata[SC_RX_EN_BIT] = st.rx_enable;
          next_st.readdata[SC_NINTH_BIT] = st.received_ninth_bit;
          next_st.readdata[SC_RX_DONE_BIT] = st.receive_done_flag;
        end
        IDX_POWER_CONTROL:      next_st.readdata[PC_VIEW_BIT] = st.error_view_select;
        IDX_SERIAL_BUFFER:      next_st.readdata[7:0] = st.serial_buffer;
        IDX_BAUD_DIV:           next_st.readdata[15:0] = st.baud_div;
        IDX_IRQ_STATUS:         next_st.readdata[IRQ_W-1:0] = st.irq_status;
        IDX_IRQ_MASK:           next_st.readdata[IRQ_W-1:0] = st.irq_mask;
        default:                next_st.readdata = '0;
      endcase
    end
    // software writes land on the ack edge
    if (wr_now) begin
      unique case (wr_idx)
        IDX_SLAVE_ADDRESS:      next_st.slave_address = avs_req_i.writedata[7:0];
        IDX_SLAVE_ADDRESS_MASK: next_st.slave_address_mask = avs_req_i.writedata[7:0];
        IDX_SERIAL_CONTROL: begin
          // R14: view select steers the write, zero only clears
          if (!st.error_view_select) next_st.mode_select_high = avs_req_i.writedata[SC_SHARED_BIT];
          else if (fe_clear_wr) next_st.frame_error_flag = 1'b0;
          next_st.mode_select_low = avs_req_i.writedata[SC_MODE_LOW_BIT];
          next_st.address_filter_enable = avs_req_i.writedata[SC_FILTER_BIT];
          next_st.rx_enable = avs_req_i.writedata[SC_RX_EN_BIT];
          next_st.received_ninth_bit = avs_req_i.writedata[SC_NINTH_BIT];
          next_st.receive_done_flag = avs_req_i.writedata[SC_RX_DONE_BIT];
        end
        IDX_POWER_CONTROL:      next_st.error_view_select = avs_req_i.writedata[PC_VIEW_BIT];
        IDX_BAUD_DIV: begin
          next_st.baud_div[7:0] = avs_req_i.writedata[7:0];
          if (avs_req_i.byteenable[1]) next_st.baud_div[15:8] = avs_req_i.writedata[15:8];
        end
        IDX_IRQ_STATUS:         next_st.irq_status = st.irq_status & ~avs_req_i.writedata[IRQ_W-1:0];
        IDX_IRQ_MASK:           next_st.irq_mask = avs_req_i.writedata[IRQ_W-1:0];
        default:                next_st.irq_mask = st.irq_mask;
      endcase
    end
    // hardware events come last so a set beats a same-cycle clear
    if (accept) begin
      next_st.serial_buffer = frame.data;
      // R13: ninth data bit kept, stop bit in ten-bit mode
      next_st.received_ninth_bit = frame.ninth;
      next_st.receive_done_flag = 1'b1;
      next_st.irq_status[IRQ_RX_DONE_BIT] = 1'b1;
    end
    // R3: only this path sets the flag, good frames never clear it
    if (fe_event) begin
      next_st.frame_error_flag = 1'b1;
      next_st.irq_status[IRQ_FE_BIT] = 1'b1;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // R11: reset zeroes address and mask
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= MAIN_RST;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // outputs
  assign avs_rsp_o.readdata    = st.readdata;
  // a frozen clock enable keeps the master waiting, else a write would be lost
  assign avs_rsp_o.waitrequest = access && !(st.ack && ce_i);
  assign irq_o                 = |(st.irq_status & st.irq_mask);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_FE_SET: assert property (ce_i && fe_event |=> st.frame_error_flag) // R1
    else $error("frame error flag not set after bad stop bit");
  AST_VIEW_READ: assert property (ce_i && avs_req_i.read && !st.ack && wr_idx == IDX_SERIAL_CONTROL |=> // R2
      st.readdata[SC_SHARED_BIT] == ($past(st.error_view_select) ? $past(st.frame_error_flag)
                                                                 : $past(st.mode_select_high)))
    else $error("shared control bit shows the wrong flag");
  AST_FE_STICKY: assert property (st.frame_error_flag && !(ce_i && fe_clear_wr) |=> st.frame_error_flag) // R3
    else $error("frame error flag dropped without a clearing write");
  AST_NINE_FILTER: assert property (ce_i && frame.valid && rx_active && nine_bit && st.address_filter_enable && // R5
      !st.receive_done_flag && !(frame.ninth && match) && !wr_now |=> !st.receive_done_flag)
    else $error("nine-bit frame accepted without address match");
  AST_NO_FILTER: assert property (ce_i && frame.valid && rx_active && !st.address_filter_enable && // R7
      !st.receive_done_flag |=> st.receive_done_flag && st.serial_buffer == $past(frame.data))
    else $error("unfiltered frame not accepted");
  AST_TEN_FILTER: assert property (ce_i && frame.valid && rx_active && ten_bit && st.address_filter_enable && // R8
      !st.receive_done_flag && !wr_now |=> st.receive_done_flag == ($past(frame.stop) && $past(match)))
    else $error("ten-bit filter decision wrong");
  AST_GIVEN: assert property (given == ((frame.data & st.slave_address_mask) == (st.slave_address & st.slave_address_mask))) // R9
    else $error("given address compare wrong");
  AST_BCAST: assert property (broadcast == // R10
      ((frame.data & (st.slave_address | st.slave_address_mask)) == (st.slave_address | st.slave_address_mask)))
    else $error("broadcast address compare wrong");
  AST_RESET_ADDR: assert property (disable iff (1'b0) $fell(sys_rst_i) |-> // R11
      st.slave_address == SLAVE_ADDRESS_RST && st.slave_address_mask == SLAVE_ADDRESS_MASK_RST && match)
    else $error("address registers not cleared by reset");
  AST_FULL_HOLD: assert property (ce_i && frame.valid && st.receive_done_flag && !wr_now |=> // R12
      st.serial_buffer == $past(st.serial_buffer) && st.received_ninth_bit == $past(st.received_ninth_bit))
    else $error("full receiver overwritten");
  AST_NINTH_STORE: assert property (ce_i && accept && nine_bit |=> st.received_ninth_bit == $past(frame.ninth)) // R13
    else $error("ninth bit not stored");
  AST_FE_CLEAR: assert property (ce_i && fe_clear_wr && !fe_event |=> // R14
      !st.frame_error_flag && st.mode_select_high == $past(st.mode_select_high))
    else $error("frame error clear failed or touched mode bit");

endmodule

// File: test/ufeam_serial_rx_tb_top.sv
// Purpose: register and frame level checks of the serial receive port
// Assumes: baud_div 1 gives 32 clocks a bit
// Notes:   bus sampled at the rising edge, before the answer moves

module ufeam_serial_rx_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ufeam_pkg::*;

  logic              ref_clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              ce_i      = 1'b1;
  logic              rxd;
  logic              irq;
  ufeam_avs_req_type req       = '0;
  ufeam_avs_rsp_type rsp;
  logic [31:0]       q;
  int                miscompares = 0;
  int                checks_done = 0;
  // filter table: byte, ninth bit, accepted
  logic [7:0]        t_byte [6] = '{8'hA0, 8'hA2, 8'hA0, 8'hFE, 8'hA5, 8'h24};
  logic              t_nine [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic              t_exp  [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  // 50 MHz clock
  initial forever #10 ref_clk_i = ~ref_clk_i;

  ufeam_serial_rx i_ufeam_serial_rx (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .avs_req_i (req),
    .avs_rsp_o (rsp),
    .rxd_i     (rxd),
    .irq_o     (irq)
  );

  ufeam_uart_peer #(.BIT_CLKS(32)) i_ufeam_uart_peer (
    .ref_clk_i (ref_clk_i),
    .line_o    (rxd)
  );

  // verdict and end of run
  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    req.read      <= !w;
    req.write     <= w;
    req.address   <= {idx, 2'b00};
    req.byteenable <= 4'hF;
    req.writedata <= {24'h0, wd};
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk_i);
      if (rsp.waitrequest === 1'b0) break;
    end
    if (n == 100) begin
      miscompares++;
      results();
    end
    // answer taken at the edge where waitrequest is low, then released
    q = rsp.readdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
    bus(1'b0, idx, 8'h0);
    chk(q[7:0] & m, exp);
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rdchk(IDX_SLAVE_ADDRESS, 8'hFF, 8'h00);
    rdchk(IDX_SLAVE_ADDRESS_MASK, 8'hFF, 8'h00);
    rdchk(8'h10, 8'hFF, 8'h00);
    bus(1'b1, IDX_BAUD_DIV, 8'h01);
    bus(1'b1, IDX_IRQ_MASK, 8'h01);
    // ten-bit mode, filter off
    bus(1'b1, IDX_SERIAL_CONTROL, 8'h50);
    i_ufeam_uart_peer.send(8'h5A, 1'b0, 1'b0, 1'b1);
    rdchk(IDX_SERIAL_CONTROL, 8'h05, 8'h05);
    rdchk(IDX_SERIAL_BUFFER, 8'hFF, 8'h5A);
    chk({7'h0, irq}, 8'h01);
    bus(1'b1, IDX_IRQ_STATUS, 8'h01);
    chk({7'h0, irq}, 8'h00);
    i_ufeam_uart_peer.send(8'h33, 1'b0, 1'b0, 1'b1);
    rdchk(IDX_SERIAL_BUFFER, 8'hFF, 8'h5A);
    // eleven-bit mode, error view on
    bus(1'b1, IDX_SERIAL_CONTROL, 8'hD0);
    bus(1'b1, IDX_POWER_CONTROL, 8'h40);
    rdchk(IDX_SERIAL_CONTROL, 8'h80, 8'h00);
    i_ufeam_uart_peer.send(8'h11, 1'b1, 1'b1, 1'b0);
    rdchk(IDX_SERIAL_CONTROL, 8'h85, 8'h85);
    rdchk(IDX_IRQ_STATUS, 8'h03, 8'h03);
    bus(1'b1, IDX_SERIAL_CONTROL, 8'hD0);
    i_ufeam_uart_peer.send(8'h22, 1'b1, 1'b0, 1'b1);
    rdchk(IDX_SERIAL_CONTROL, 8'h85, 8'h81);
    bus(1'b1, IDX_SERIAL_CONTROL, 8'h50);
    rdchk(IDX_SERIAL_CONTROL, 8'h80, 8'h00);
    bus(1'b1, IDX_POWER_CONTROL, 8'h00);
    rdchk(IDX_SERIAL_CONTROL, 8'h80, 8'h80);
    // address filter, given 1010_0x0x, broadcast 1111_111x
    bus(1'b1, IDX_SLAVE_ADDRESS, 8'hA4);
    bus(1'b1, IDX_SLAVE_ADDRESS_MASK, 8'hFA);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, IDX_SERIAL_CONTROL, 8'hF0);
      i_ufeam_uart_peer.send(t_byte[i], 1'b1, t_nine[i], 1'b1);
      rdchk(IDX_SERIAL_CONTROL, 8'h01, {7'h0, t_exp[i]});
    end
    // ten-bit mode, filter on: bad stop refused
    bus(1'b1, IDX_SERIAL_CONTROL, 8'h70);
    i_ufeam_uart_peer.send(8'hA0, 1'b0, 1'b0, 1'b0);
    rdchk(IDX_SERIAL_CONTROL, 8'h01, 8'h00);
    i_ufeam_uart_peer.send(8'hA0, 1'b0, 1'b0, 1'b1);
    rdchk(IDX_SERIAL_CONTROL, 8'h01, 8'h01);
    // mid-run reset restores the address registers
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rdchk(IDX_SLAVE_ADDRESS, 8'hFF, 8'h00);
    rdchk(IDX_SLAVE_ADDRESS_MASK, 8'hFF, 8'h00);
    bus(1'b1, IDX_BAUD_DIV, 8'h01);
    // filter off accepts a byte, which after reset (zero mask) matches the given address anyway
    bus(1'b1, IDX_SERIAL_CONTROL, 8'h50);
    i_ufeam_uart_peer.send(8'h24, 1'b0, 1'b0, 1'b1);
    rdchk(IDX_SERIAL_BUFFER, 8'hFF, 8'h24);
    // frozen clock enable: a frame on the line is not seen
    bus(1'b1, IDX_SERIAL_CONTROL, 8'h50);
    ce_i <= 1'b0;
    i_ufeam_uart_peer.send(8'h77, 1'b0, 1'b0, 1'b1);
    ce_i <= 1'b1;
    rdchk(IDX_SERIAL_CONTROL, 8'h01, 8'h00);
    rdchk(IDX_SERIAL_BUFFER, 8'hFF, 8'h24);
    results();
  end
endmodule

// File: test/ufeam_uart_peer.sv
// Purpose: remote serial transmitter on the shared receive line
// Assumes: caller enters send just after a rising clock edge
// Notes:   line idles high between frames, as an async link does

module ufeam_uart_peer #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic ref_clk_i,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle level before the first frame
  initial line_o = 1'b1;

  // one frame, lsb first, then one idle bit so the next start is an edge
  // ninth bit marks address
  task automatic send(input logic [7:0] d, input logic nine_mode, input logic ninth, input logic stop);
    logic [10:0] f;
    int          nb;
    f  = nine_mode ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    nb = nine_mode ? 11 : 10;
    for (int i = 0; i < nb; i++) begin
      line_o <= f[i];
      repeat (BIT_CLKS) @(posedge ref_clk_i);
    end
    line_o <= 1'b1;
    repeat (BIT_CLKS) @(posedge ref_clk_i);
  endtask
endmodule
